// *** sdb_core.sv ***
// Quad-bank SDRAM access core: command decode, bank state, bursts, refresh watch.
// Assumes pins are synchronous to aclk and a 32-bit AXI4-Lite master for setup.
`timescale 1ns/1ps
// How it works
// - All pins are sampled only at the rising clock edge.
// - Four banks of 8192 rows; columns 2048, 1024 or 512 by width.
// - Reads and writes are serviced only in a bank with an open row.
// - ACTIVE takes bank from the bank lines and row from thirteen address lines.
// - Address with READ or WRITE gives the burst's first column.
// - Burst columns are generated internally in the programmed ordering.
// - Burst length 1, 2, 4, 8 or full row; terminate stops early.
// - Auto precharge closes the row by itself when the burst finishes.
// - A new column command may arrive every cycle and restarts the burst.
// - One bank may be precharged while another is being accessed.
// - Auto refresh is counted; clock enable low gives power-down.
// - Automotive grade needs a full refresh set within 16 ms.
// - Address line ten with READ or WRITE requests auto precharge.
// - Chip select high masks commands; running bursts carry on.
module sdb_core
#(
   parameter int ROW_W        = sdb_pkg::ROW_BITS,
   parameter int COL_W        = sdb_pkg::COL_BITS,
   parameter int DQ_W         = sdb_pkg::DQ_W,
   parameter int REF_STD_CYC  = sdb_pkg::REF_WIN_STD_CYC,
   parameter int REF_AUTO_CYC = sdb_pkg::REF_WIN_AUTO_CYC
)
(
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic                       cke,
   input  wire sdb_pkg::sdb_cmd_type       cmd,
   input  wire logic [DQ_W-1:0]            dq_i,
   output logic      [DQ_W-1:0]            dq_o,
   output logic                            dq_oe,
   input  wire logic [sdb_pkg::AXI_AW-1:0] s_awaddr,
   input  wire logic                       s_awvalid,
   output logic                            s_awready,
   input  wire logic [31:0]                s_wdata,
   input  wire logic [3:0]                 s_wstrb,
   input  wire logic                       s_wvalid,
   output logic                            s_wready,
   output logic      [1:0]                 s_bresp,
   output logic                            s_bvalid,
   input  wire logic                       s_bready,
   input  wire logic [sdb_pkg::AXI_AW-1:0] s_araddr,
   input  wire logic                       s_arvalid,
   output logic                            s_arready,
   output logic      [31:0]                s_rdata,
   output logic      [1:0]                 s_rresp,
   output logic                            s_rvalid,
   input  wire logic                       s_rready
);
   import sdb_pkg::*;

   localparam int NB    = NUM_BANKS;
   localparam int IDX_W = 2 + ROW_W + COL_W;

   // Cell array, one word per bank/row/column
   logic [DQ_W-1:0]  mem [0:(2**IDX_W)-1];

   logic [ROW_W-1:0] row_q [NB];
   logic [NB-1:0]    open_q;
   sdb_bst_type      bst_q;
   logic [1:0]       bank_q;
   logic [COL_W-1:0] start_q;
   logic [COL_W-1:0] cnt_q;
   logic             ap_q;
   logic [2:0]       bl_q;
   logic             bt_q;
   logic [2:0]       cl_q;
   logic             grade_q;
   logic [3:0]       err_q;
   logic [3:0]       err_set;
   logic [3:0]       err_clr;
   logic [REF_CNT_W-1:0] ref_cnt_q;
   logic [31:0]      win_q;
   logic             win_end;
   logic [DQ_W-1:0]  pd0_q;
   logic [DQ_W-1:0]  pd1_q;
   logic [1:0]       pv_q;
   logic             dqm_q;

   // Command decode; chip select high masks every command, but not dqm or a running burst
   logic       sel;
   logic [2:0] op;
   logic       is_act;
   logic       is_rd;
   logic       is_wr;
   logic       is_pre;
   logic       is_bst;
   logic       is_ref;
   logic       col_cmd;
   logic       all_idle;
   assign sel      = cke && !cmd.cs_n;
   assign op       = {cmd.ras_n, cmd.cas_n, cmd.we_n};
   assign is_act   = sel && (op == CMD_ACT);
   assign is_rd    = sel && (op == CMD_RD);
   assign is_wr    = sel && (op == CMD_WR);
   assign is_pre   = sel && (op == CMD_PRE);
   assign is_bst   = sel && (op == CMD_BST);
   assign is_ref   = sel && (op == CMD_REF);
   assign col_cmd  = (is_rd || is_wr) && open_q[cmd.ba];
   assign all_idle = (open_q == '0) && (bst_q == B_IDLE);

   // Column field; the x4 part uses line eleven above line nine
   logic [10:0]      col_wide;
   logic [COL_W-1:0] cmd_col;
   assign col_wide = {cmd.addr[11], cmd.addr[9:0]};
   assign cmd_col  = col_wide[COL_W-1:0];

   // Running burst kind
   logic cont;
   logic cont_wr;
   always_comb
   begin
      cont    = 1'b0;
      cont_wr = 1'b0;
      unique case (bst_q)
         B_IDLE: cont = 1'b0;
         B_RD:   cont = 1'b1;
         B_WR:
         begin
            cont    = 1'b1;
            cont_wr = 1'b1;
         end
         default: cont = 1'b0;
      endcase
   end

   // Beat selection: a new column command restarts at beat zero
   logic             pre_hit;
   logic             beat;
   logic             beat_wr;
   logic             beat_ap;
   logic [1:0]       beat_bank;
   logic [COL_W-1:0] beat_start;
   logic [COL_W-1:0] beat_cnt;
   logic [COL_W-1:0] beat_col;
   logic             last;
   logic             ap_close_old;
   assign pre_hit    = is_pre && (cmd.addr[AP_BIT] || (cmd.ba == bank_q));
   assign beat       = col_cmd || (cont && cke && !is_bst && !pre_hit);
   assign beat_wr    = col_cmd ? is_wr : cont_wr;
   assign beat_ap    = col_cmd ? cmd.addr[AP_BIT] : ap_q;
   assign beat_bank  = col_cmd ? cmd.ba : bank_q;
   assign beat_start = col_cmd ? cmd_col : start_q;
   assign beat_cnt   = col_cmd ? '0 : cnt_q;
   assign last       = !bl_q[2] && (beat_cnt == COL_W'(bl_beats(bl_q) - 4'h1));
   // An auto-precharge burst cut by terminate or by a column command to another bank still closes its own bank
   assign ap_close_old = cont && cke && ap_q && (is_bst || (col_cmd && cmd.ba != bank_q));

   sdb_col_gen #(.COLW(COL_W)) u_col
   (
      .start   (beat_start),
      .cnt     (beat_cnt),
      .bl_code (bl_q),
      .ileave  (bt_q),
      .col     (beat_col)
   );

   // Bank open/idle state and row latches
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         open_q <= '0;
         for (int b = 0; b < NB; b++)
            row_q[b] <= '0;
      end
      else if (cke)
      begin
         for (int b = 0; b < NB; b++)
         begin
            if (is_act && (cmd.ba == 2'(b)) && !open_q[b])
            begin
               open_q[b] <= 1'b1;
               row_q[b]  <= cmd.addr[ROW_W-1:0];
            end
            if (is_pre && (cmd.addr[AP_BIT] || (cmd.ba == 2'(b))))
               open_q[b] <= 1'b0;
            if (beat && last && beat_ap && (beat_bank == 2'(b)))
               open_q[b] <= 1'b0;
            if (ap_close_old && (bank_q == 2'(b)))
               open_q[b] <= 1'b0;
         end
      end
   end

   // Burst sequencer; counter steps once per beat
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bst_q   <= B_IDLE;
         cnt_q   <= '0;
         start_q <= '0;
         bank_q  <= '0;
         ap_q    <= 1'b0;
      end
      else if (cke)
      begin
         if (beat && !last)
         begin
            bst_q   <= beat_wr ? B_WR : B_RD;
            cnt_q   <= beat_cnt + 1'b1;
            start_q <= beat_start;
            bank_q  <= beat_bank;
            ap_q    <= beat_ap;
         end
         else if (beat || is_bst || pre_hit)
            bst_q <= B_IDLE;
      end
   end

   // Array access; write data masked by dqm at the same edge
   logic [IDX_W-1:0] mem_idx;
   assign mem_idx = {beat_bank, row_q[beat_bank], beat_col};
   always_ff @(posedge aclk)
   begin
      if (cke && beat && beat_wr && !cmd.dqm)
         mem[mem_idx] <= dq_i;
   end

   // Read pipe; latency 2 or 3, dqm turns the driver off two edges later
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pd0_q <= '0;
         pd1_q <= '0;
         pv_q  <= '0;
         dqm_q <= 1'b0;
         dq_o  <= '0;
         dq_oe <= 1'b0;
      end
      else if (cke)
      begin
         pd0_q <= mem[mem_idx];
         pd1_q <= pd0_q;
         pv_q  <= {pv_q[0], beat && !beat_wr};
         dqm_q <= cmd.dqm;
         dq_o  <= (cl_q == 3'h3) ? pd1_q : pd0_q;
         dq_oe <= ((cl_q == 3'h3) ? pv_q[1] : pv_q[0]) && !dqm_q;
      end
   end

   // Refresh watch; window follows the temperature grade
   int win_lim;
   assign win_lim = grade_q ? REF_AUTO_CYC : REF_STD_CYC;
   assign win_end = (win_q == 32'(win_lim - 1));
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         win_q     <= '0;
         ref_cnt_q <= '0;
      end
      else if (cke)
      begin
         if (win_end)
         begin
            win_q     <= '0;
            ref_cnt_q <= (is_ref && all_idle) ? REF_CNT_W'(1) : '0;
         end
         else
         begin
            win_q <= win_q + 1'b1;
            if (is_ref && all_idle && (ref_cnt_q != '1))
               ref_cnt_q <= ref_cnt_q + 1'b1;
         end
      end
   end

   // Sticky errors: refused activate, access to idle bank, refresh while busy, late
   assign err_set = {win_end && (ref_cnt_q < REF_ROWS),
                     is_ref && !all_idle,
                     (is_rd || is_wr) && !open_q[cmd.ba],
                     is_act && open_q[cmd.ba]};
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         err_q <= '0;
      else if (cke)
         err_q <= (err_q & ~err_clr) | err_set;   // Set wins over clear
   end

   // AXI4-Lite write channel: address and data taken in either order
   logic [AXI_AW-1:0] awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              aw_have_q;
   logic              w_have_q;
   logic              wr_go;
   assign wr_go = aw_have_q && w_have_q && !s_bvalid;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_awready <= 1'b0;
         s_wready  <= 1'b0;
         s_bvalid  <= 1'b0;
         s_bresp   <= RESP_OKAY;
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
      end
      else if (cke)
      begin
         if (s_awvalid && s_awready)
         begin
            aw_have_q <= 1'b1;
            awaddr_q  <= s_awaddr;
            s_awready <= 1'b0;
         end
         else if (!aw_have_q && !s_bvalid)
            s_awready <= 1'b1;
         if (s_wvalid && s_wready)
         begin
            w_have_q <= 1'b1;
            wdata_q  <= s_wdata;
            wstrb_q  <= s_wstrb;
            s_wready <= 1'b0;
         end
         else if (!w_have_q && !s_bvalid)
            s_wready <= 1'b1;
         if (wr_go)
         begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            s_bvalid  <= 1'b1;
            s_bresp   <= reg_known(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_bvalid && s_bready)
            s_bvalid <= 1'b0;
      end
   end

   // Mode and grade; changing the mode mid-burst reshapes the running burst
   assign err_clr = (wr_go && (awaddr_q == STAT_OFS) && wstrb_q[1]) ?
                    wdata_q[ERR_LSB+:4] : 4'h0;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bl_q    <= BL_RST;
         bt_q    <= BT_RST;
         cl_q    <= CL_RST;
         grade_q <= GRADE_RST;
      end
      else if (cke && wr_go && wstrb_q[0])
      begin
         if (awaddr_q == MODE_OFS)
         begin
            bl_q <= wdata_q[BL_LSB+:3];
            bt_q <= wdata_q[BT_BIT];
            cl_q <= wdata_q[CL_LSB+:3];
         end
         if (awaddr_q == CTRL_OFS)
            grade_q <= wdata_q[GRADE_BIT];
      end
   end

   // AXI4-Lite read channel
   logic [31:0] rd_word;
   always_comb
   begin
      rd_word = 32'h0000_0000;
      case (s_araddr)
         MODE_OFS:
         begin
            rd_word[BL_LSB+:3] = bl_q;
            rd_word[BT_BIT]    = bt_q;
            rd_word[CL_LSB+:3] = cl_q;
         end
         CTRL_OFS: rd_word[GRADE_BIT] = grade_q;
         STAT_OFS:
         begin
            rd_word[OPEN_LSB+:4] = open_q;
            rd_word[BUSY_BIT]    = cont;
            rd_word[ERR_LSB+:4]  = err_q;
         end
         REFC_OFS: rd_word[REFC_LSB+:REF_CNT_W] = ref_cnt_q;
         default:  rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b0;
         s_rdata   <= '0;
         s_rresp   <= RESP_OKAY;
      end
      else if (cke)
      begin
         if (s_arvalid && s_arready)
         begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b1;
            s_rdata   <= rd_word;
            s_rresp   <= reg_known(s_araddr) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_rvalid && s_rready)
            s_rvalid <= 1'b0;
         else if (!s_rvalid)
            s_arready <= 1'b1;
      end
   end

   // Checks on bank, burst and refresh behaviour
   cs_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (cke && cmd.cs_n && bst_q == B_IDLE) |=> (bst_q == B_IDLE))
      else $error("burst started while chip select was high");
   act_open_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (is_act && !open_q[cmd.ba]) |=>
      (open_q[$past(cmd.ba)] && row_q[$past(cmd.ba)] == $past(cmd.addr[ROW_W-1:0])))
      else $error("activate did not open the addressed row");
   act_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (is_act && open_q[cmd.ba]) |=> (err_q[0] && $stable(row_q[$past(cmd.ba)])))
      else $error("activate to open bank not refused");
   idle_access_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ((is_rd || is_wr) && !open_q[cmd.ba] && !cont) |=> (err_q[1] && bst_q == B_IDLE))
      else $error("access to idle bank was serviced");
   col_accept_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (col_cmd && !last) |=> (bst_q != B_IDLE && start_q == $past(cmd_col) && cnt_q == 1))
      else $error("column command not taken");
   burst_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (cont && cke && !col_cmd && !is_bst && !pre_hit && !last) |=>
      (cnt_q == $past(cnt_q) + 1'b1))
      else $error("burst counter did not advance");
   ap_close_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (beat && last && beat_ap) |=> !open_q[$past(beat_bank)])
      else $error("auto precharge left row open");
   bst_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
      is_bst |=> (bst_q == B_IDLE))
      else $error("burst terminate ignored");
   pre_other_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (cont && is_pre && !cmd.addr[AP_BIT] && cmd.ba != bank_q && !last) |=>
      (bst_q == $past(bst_q) && !open_q[$past(cmd.ba)]))
      else $error("precharge of other bank disturbed burst");
   rd_lat_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (beat && !beat_wr && !cmd.dqm && cl_q == 3'h2) ##1 (cke && cl_q == 3'h2) |=> dq_oe)
      else $error("read data not driven at latency two");
   ref_late_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (cke && win_end && ref_cnt_q < REF_ROWS) |=> (err_q[3] && ref_cnt_q <= 1))
      else $error("late refresh not flagged");
   ref_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (is_ref && !all_idle && !win_end) |=> (err_q[2] && $stable(ref_cnt_q)))
      else $error("refresh with open bank was counted");

endmodule : sdb_core

// *** sdb_pkg.sv ***
// Shared constants, types and helpers for the SDRAM bank/burst access core.
// Assumes a single 10 MHz clock and a 32-bit AXI4-Lite register port.
package sdb_pkg;

   // Array geometry
   localparam int NUM_BANKS = 4;
   localparam int ROW_BITS  = 13;
   localparam int COL_BITS  = 9;
   localparam int DQ_W      = 16;
   localparam int ADDR_W    = 13;
   localparam int AP_BIT    = 10;

   // Command codes {ras_n, cas_n, we_n}, meaningful with cs_n low
   localparam logic [2:0] CMD_ACT  = 3'h3;
   localparam logic [2:0] CMD_RD   = 3'h5;
   localparam logic [2:0] CMD_WR   = 3'h4;
   localparam logic [2:0] CMD_PRE  = 3'h2;
   localparam logic [2:0] CMD_BST  = 3'h6;
   localparam logic [2:0] CMD_REF  = 3'h1;

   // Refresh timing
   localparam int CLK_PERIOD_NS    = 100;
   localparam int REF_WIN_STD_MS   = 64;
   localparam int REF_WIN_AUTO_MS  = 16;
   localparam int REF_WIN_STD_CYC  = REF_WIN_STD_MS * 1000000 / CLK_PERIOD_NS;
   localparam int REF_WIN_AUTO_CYC = REF_WIN_AUTO_MS * 1000000 / CLK_PERIOD_NS;
   localparam int REF_CNT_W        = 14;
   localparam logic [13:0] REF_ROWS = 14'h2000;

   // Register map and fields
   localparam int AXI_AW = 8;
   localparam logic [7:0] MODE_OFS = 8'h00;
   localparam logic [7:0] CTRL_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] REFC_OFS = 8'h0C;
   localparam int BL_LSB    = 0;
   localparam int BT_BIT    = 3;
   localparam int CL_LSB    = 4;
   localparam int GRADE_BIT = 0;
   localparam int OPEN_LSB  = 0;
   localparam int BUSY_BIT  = 4;
   localparam int ERR_LSB   = 8;
   localparam int REFC_LSB  = 0;
   localparam logic [2:0] BL_RST    = 3'h3;
   localparam logic       BT_RST    = 1'b0;
   localparam logic [2:0] CL_RST    = 3'h3;
   localparam logic       GRADE_RST = 1'b0;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Pin command group sampled each rising edge
   typedef struct packed {
      logic        cs_n;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic        dqm;
      logic [1:0]  ba;
      logic [12:0] addr;
   } sdb_cmd_type;

   typedef enum logic [2:0] {B_IDLE = 3'h1, B_RD = 3'h2, B_WR = 3'h4} sdb_bst_type;

   // Beats per burst; zero for full page (code bit 2 set)
   function automatic logic [3:0] bl_beats(input logic [2:0] code);
      return code[2] ? 4'h0 : (4'h1 << code[1:0]);
   endfunction : bl_beats

   function automatic logic reg_known(input logic [7:0] a);
      return (a == MODE_OFS) || (a == CTRL_OFS) || (a == STAT_OFS) || (a == REFC_OFS);
   endfunction : reg_known

endpackage : sdb_pkg

// *** sdb_col_gen.sv ***
// Column generator: column of one burst beat from start column and beat count.
// Assumes the burst length code and ordering bit are stable during a burst.
`timescale 1ns/1ps
module sdb_col_gen
#(
   parameter int COLW = sdb_pkg::COL_BITS
)
(
   input  wire logic [COLW-1:0] start,
   input  wire logic [COLW-1:0] cnt,
   input  wire logic [2:0]      bl_code,
   input  wire logic            ileave,
   output logic      [COLW-1:0] col
);
   import sdb_pkg::*;

   logic [COLW-1:0] mask;

   // Wrap inside the burst-sized block; full page wraps over the whole row
   always_comb
   begin
      mask = COLW'(bl_beats(bl_code)) - 1'b1;
      if (bl_code[2])
         col = start + cnt;
      else if (ileave)
         col = (start & ~mask) | ((start ^ cnt) & mask);
      else
         col = (start & ~mask) | ((start + cnt) & mask);
   end

endmodule : sdb_col_gen

// *** sdb_ctl_model.sv ***
// Memory controller model: drives pin commands and write data to the core.
// Assumes the bench calls its tasks just after a rising edge of aclk.
`timescale 1ns/1ps
module sdb_ctl_model
(
   input  wire logic                aclk,
   output sdb_pkg::sdb_cmd_type     cmd,
   output logic [sdb_pkg::DQ_W-1:0] dq_i,
   output logic                     cke
);
   import sdb_pkg::*;

   // Deselected and clock enabled from time zero
   initial
   begin
      cmd  = '1;
      dq_i = '0;
      cke  = 1'b1;
   end

   // One command per edge, held until its sampling edge
   // No self refresh op exists, so it is never requested
   task automatic put(input logic s, input logic [2:0] op, input logic [1:0] b,
                      input logic [12:0] a, input logic [DQ_W-1:0] d);
      cmd  <= {s, op, 1'b0, b, a};
      dq_i <= d;
      @(posedge aclk);
   endtask : put

   // Undriven data flips so a stale word never passes as written
   task automatic issue(input logic s, input logic [2:0] op, input logic [1:0] b,
                        input logic [12:0] a);
      put(s, op, b, a, ~dq_i);
   endtask : issue

   task automatic nop(input int n);
      repeat (n) issue(1'b0, 3'h7, 2'h0, 13'h0);
   endtask : nop

   // Read with the data mask up; its data must never reach the pins
   task automatic mask_rd(input logic [1:0] b, input logic [12:0] a);
      cmd <= {1'b0, CMD_RD, 1'b1, b, a};
      @(posedge aclk);
   endtask : mask_rd

   // Clock enable low for n edges, with an activate that must not land
   task automatic pdown(input int n);
      cke <= 1'b0;
      repeat (n) put(1'b0, CMD_ACT, 2'h2, 13'h0, dq_i);
      cke <= 1'b1;
   endtask : pdown
endmodule : sdb_ctl_model

// *** tb_top.sv ***
// Bench for the access core: AXI setup, pin bursts, bank and refresh status.
// Assumes the controller model drives the pins; only the automotive window expires.
`timescale 1ns/1ps
module tb_top;
   import sdb_pkg::*;
   logic            aclk, aresetn = 1'b0;
   sdb_cmd_type     cmd;
   logic            cke, dq_oe;
   logic [DQ_W-1:0] dq_i, dq_o;
   logic [7:0]      s_awaddr = '0, s_araddr = '0;
   logic [31:0]     s_wdata = '0, s_rdata;
   logic [3:0]      s_wstrb = 4'hF;
   logic [1:0]      s_bresp, s_rresp;
   logic            s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
   logic            s_arvalid = 1'b0, s_rready = 1'b0;
   logic            s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [DQ_W-1:0] d [8];
   logic [DQ_W-1:0] dq_exp [$];
   logic [33:0]     ax_exp [$];
   int              fails = 0, samples_checked = 0, seed = 64287;

   initial
   begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   // Small array; automotive window short enough to run out once near the end
   sdb_core #(.ROW_W(4), .REF_AUTO_CYC(30000)) DUT
   (
      .aclk, .aresetn, .cke, .cmd, .dq_i, .dq_o, .dq_oe,
      .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
      .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
      .s_rdata, .s_rresp, .s_rvalid, .s_rready
   );
   sdb_ctl_model ctl (.aclk(aclk), .cmd(cmd), .dq_i(dq_i), .cke(cke));

   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up

   // Results meet the oldest note as they appear
   always @(posedge aclk)
   begin
      if (dq_oe === 1'b1 && dq_exp.size() == 0)
         chk(34'h1, 34'h0);
      else if (dq_oe === 1'b1)
         chk({18'h0, dq_o}, {18'h0, dq_exp.pop_front()});
      if (s_bvalid === 1'b1 && s_bready)
         chk({s_bresp, 32'h0}, ax_exp.pop_front());
      if (s_rvalid === 1'b1 && s_rready)
         chk({s_rresp, s_rdata}, ax_exp.pop_front());
   end

   // One AXI4-Lite transfer; e is the expected response and read word
   task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] w,
                      input logic [33:0] e);
      int n;
      ax_exp.push_back(e);
      if (wr)
      begin
         s_awaddr  <= a;
         s_wdata   <= w;
         s_awvalid <= 1'b1;
         s_wvalid  <= 1'b1;
         s_bready  <= 1'b1;
      end
      else
      begin
         s_araddr  <= a;
         s_arvalid <= 1'b1;
         s_rready  <= 1'b1;
      end
      for (n = 0; n < 40; n++)
      begin
         @(posedge aclk);
         if (s_awvalid && s_awready) s_awvalid <= 1'b0;
         if (s_wvalid && s_wready) s_wvalid <= 1'b0;
         if (s_arvalid && s_arready) s_arvalid <= 1'b0;
         if (s_bvalid || s_rvalid) break;
      end
      s_bready <= 1'b0;
      s_rready <= 1'b0;
      // One idle edge so the next transfer never raises what was just dropped
      @(posedge aclk);
      if (n == 40)
      begin
         fails++;
         wrap_up();
      end
   endtask : axi

   // Read with n beats expected; block wrap order within bl
   task automatic rd(input logic [1:0] b, input logic [12:0] a, input int bl, input int n,
                     input bit il = 1'b0);
      for (int k = 0; k < n; k++)
         dq_exp.push_back(d[(a[2:0] & ~(bl - 1)) | ((il ? a[2:0] ^ k : a[2:0] + k) & (bl - 1))]);
      ctl.issue(1'b0, CMD_RD, b, a);
   endtask : rd

   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi(1'b0, MODE_OFS, 32'h0, {RESP_OKAY, 32'h33});
      axi(1'b0, 8'h10, 32'h0, {RESP_SLVERR, 32'h0});
      axi(1'b1, 8'h10, 32'h1, {RESP_SLVERR, 32'h0});
      axi(1'b1, CTRL_OFS, 32'h1, {RESP_OKAY, 32'h0});
      axi(1'b0, CTRL_OFS, 32'h0, {RESP_OKAY, 32'h1});
      axi(1'b1, MODE_OFS, 32'h23, {RESP_OKAY, 32'h0});
      ctl.issue(1'b0, CMD_ACT, 2'h3, 13'($random(seed)));
      for (int k = 0; k < 8; k++)
         d[k] = 16'($random(seed));
      for (int k = 0; k < 8; k++)
         ctl.put(1'b0, (k == 0) ? CMD_WR : 3'h7, 2'h3, 13'h0, d[k]);
      ctl.nop(2);
      // Every finite length, counted beat by beat
      for (int c = 0; c < 4; c++)
      begin
         axi(1'b1, MODE_OFS, 32'h20 | c, {RESP_OKAY, 32'h0});
         rd(2'h3, 13'h0, 1 << c, 1 << c);
         ctl.nop(12);
      end
      // Interleaved order at latency three, then a full row cut by terminate
      axi(1'b1, MODE_OFS, 32'h3A, {RESP_OKAY, 32'h0});
      rd(2'h3, 13'h1, 4, 4, 1'b1);
      ctl.nop(12);
      axi(1'b1, MODE_OFS, 32'h24, {RESP_OKAY, 32'h0});
      rd(2'h3, 13'h0, 8, 8);
      ctl.nop(7);
      ctl.issue(1'b0, CMD_BST, 2'h3, 13'h0);
      ctl.nop(4);
      axi(1'b1, MODE_OFS, 32'h20, {RESP_OKAY, 32'h0});
      ctl.mask_rd(2'h3, 13'h0);
      ctl.nop(4);
      axi(1'b1, MODE_OFS, 32'h22, {RESP_OKAY, 32'h0});
      rd(2'h3, 13'h5, 4, 1);
      rd(2'h3, 13'h2, 4, 4);
      ctl.issue(1'b0, CMD_ACT, 2'h1, 13'h0);
      ctl.nop(2);
      rd(2'h3, 13'h400, 4, 4);
      ctl.issue(1'b0, CMD_PRE, 2'h1, 13'h0);
      ctl.nop(8);
      axi(1'b0, STAT_OFS, 32'h0, {RESP_OKAY, 32'h0});
      rd(2'h1, 13'h0, 4, 0);
      ctl.issue(1'b0, CMD_ACT, 2'h0, 13'h0);
      ctl.issue(1'b0, CMD_ACT, 2'h0, 13'h0);
      ctl.issue(1'b1, CMD_ACT, 2'h2, 13'h0);
      ctl.pdown(3);
      ctl.nop(2);
      axi(1'b0, STAT_OFS, 32'h0, {RESP_OKAY, 32'h301});
      s_wstrb <= 4'h1;
      axi(1'b1, STAT_OFS, 32'h300, {RESP_OKAY, 32'h0});
      s_wstrb <= 4'hF;
      axi(1'b0, STAT_OFS, 32'h0, {RESP_OKAY, 32'h301});
      axi(1'b1, STAT_OFS, 32'h300, {RESP_OKAY, 32'h0});
      axi(1'b0, STAT_OFS, 32'h0, {RESP_OKAY, 32'h1});
      ctl.issue(1'b0, CMD_REF, 2'h0, 13'h0);
      ctl.issue(1'b0, CMD_PRE, 2'h0, 13'h400);
      ctl.issue(1'b0, CMD_REF, 2'h0, 13'h0);
      ctl.nop(2);
      axi(1'b0, REFC_OFS, 32'h0, {RESP_OKAY, 32'h1});
      axi(1'b0, STAT_OFS, 32'h0, {RESP_OKAY, 32'h400});
      // Too few refreshes: only the short automotive window runs out here
      repeat (30000) @(posedge aclk);
      axi(1'b0, STAT_OFS, 32'h0, {RESP_OKAY, 32'hC00});
      axi(1'b0, REFC_OFS, 32'h0, {RESP_OKAY, 32'h0});
      // Second reset in mid-run brings back mode defaults and clears status
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi(1'b0, MODE_OFS, 32'h0, {RESP_OKAY, 32'h33});
      axi(1'b0, STAT_OFS, 32'h0, {RESP_OKAY, 32'h0});
      chk(dq_exp.size(), 34'h0);
      wrap_up();
   end
endmodule : tb_top
